// [hbsrt_defs.svh]
// Purpose: shared constants of the host bus front end
// Assumes: included by the package and by every design file
// Notes: definitions only
`ifndef HBSRT_DEFS_SVH
`define HBSRT_DEFS_SVH

`define HBSRT_ADDR_W 21
`define HBSRT_DATA_W 32
`define HBSRT_TO_W 8
`define HBSRT_SMODE_W 2
`define HBSRT_NSTROBE 3
`define HBSRT_IDX_CS 0
`define HBSRT_IDX_WR 1
`define HBSRT_IDX_RD 2
`define HBSRT_SMODE_ALL3 2'h0
`define HBSRT_SMODE_MAJ 2'h1
`define HBSRT_SMODE_P12 2'h2
`define HBSRT_SMODE_P1 2'h3
`define HBSRT_STROBE_IDLE 3'h7
`define HBSRT_TO_ZERO 8'h00
`define HBSRT_TO_ONE 8'h01
`define HBSRT_ADDR_RST 21'h0_0000
`define HBSRT_DATA_RST 32'h0000_0000

`endif

// [hbsrt_pkg.sv]
// Purpose: types of the host bus front end
// Assumes: hbsrt_defs.svh in the include path
// Notes: constants live in the header, types here
`include "hbsrt_defs.svh"
`default_nettype none

package hbsrt_pkg;

  // address and write data of one host access
  typedef struct packed {
    logic [`HBSRT_ADDR_W-1:0] addr;
    logic [`HBSRT_DATA_W-1:0] data;
  } hbsrt_req_s;

  // access sequencer states
  typedef enum logic [1:0] {
    HBSRT_IDLE,
    HBSRT_READ_WAIT,
    HBSRT_READ_DONE,
    HBSRT_WRITE_HOLD
  } hbsrt_state_e;

  typedef logic [`HBSRT_NSTROBE-1:0] hbsrt_strobe_t;

endpackage : hbsrt_pkg

`default_nettype wire

// [hbsrt_sync3.sv]
// Purpose: three-flop synchroniser for host strobes
// Assumes: strobes are idle high
// Notes: a change counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
`include "hbsrt_defs.svh"

module hbsrt_sync3 import hbsrt_pkg::*; #(
  parameter int WIDTH = `HBSRT_NSTROBE
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;
  logic [WIDTH-1:0] level_ff;
  logic [WIDTH-1:0] nxt_level;

  // synchroniser chain, first stage feeds only the second
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_ff <= '1;
      stage2_ff <= '1;
      stage3_ff <= '1;
    end else begin
      meta_ff <= i_async;   // RULE18
      stage2_ff <= meta_ff;
      stage3_ff <= stage2_ff;
    end
  end

  // accept a new level only where stages two and three agree
  assign nxt_level = (~(stage2_ff ^ stage3_ff) & stage3_ff) |
                     ((stage2_ff ^ stage3_ff) & level_ff);

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      level_ff <= '1;
    end else begin
      level_ff <= nxt_level;
    end
  end

  assign o_level = level_ff;

endmodule : hbsrt_sync3

`default_nettype wire

// [hbsrt_strobe_filter.sv]
// Purpose: three sample points and selectable strobe filter
// Assumes: inputs already synchronised to i_clock
// Notes: point 1 is the oldest sample, point 3 the newest
`timescale 1ns/1ps
`default_nettype none
`include "hbsrt_defs.svh"

module hbsrt_strobe_filter import hbsrt_pkg::*; (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire hbsrt_strobe_t i_level,
  input wire logic [`HBSRT_SMODE_W-1:0] i_mode,
  output hbsrt_strobe_t o_point2,
  output hbsrt_strobe_t o_level
);

  hbsrt_strobe_t pt1_ff;
  hbsrt_strobe_t pt2_ff;
  hbsrt_strobe_t pt3_ff;
  hbsrt_strobe_t level_ff;
  hbsrt_strobe_t nxt_level;

  // pick a level from the three samples
  function automatic logic decide(input logic [`HBSRT_SMODE_W-1:0] mode,
                                  input logic p1, input logic p2,
                                  input logic p3, input logic prev);
    case (mode)
      `HBSRT_SMODE_ALL3: decide = (p1 == p2 && p2 == p3) ? p1 : prev;
      `HBSRT_SMODE_MAJ: decide = (p1 & p2) | (p1 & p3) | (p2 & p3);
      `HBSRT_SMODE_P12: decide = (p1 == p2) ? p1 : prev;
      `HBSRT_SMODE_P1: decide = p1;
      default: decide = prev;
    endcase
  endfunction : decide

  // sample point chain
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      pt3_ff <= `HBSRT_STROBE_IDLE;
      pt2_ff <= `HBSRT_STROBE_IDLE;
      pt1_ff <= `HBSRT_STROBE_IDLE;
    end else begin
      pt3_ff <= i_level;   // RULE4
      pt2_ff <= pt3_ff;
      pt1_ff <= pt2_ff;
    end
  end

  // same filter for every strobe, read or write alike
  for (genvar g = 0; g < `HBSRT_NSTROBE; g++) begin : g_bit
    assign nxt_level[g] = decide(i_mode, pt1_ff[g], pt2_ff[g], // RULE7
                                 pt3_ff[g], level_ff[g]);
  end

  // RULE5 RULE6
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      level_ff <= `HBSRT_STROBE_IDLE;
    end else begin
      level_ff <= nxt_level;
    end
  end

  assign o_point2 = pt2_ff;
  assign o_level = level_ff;

  AST_ALL3_AGREE: assert property ( // RULE5
    @(posedge i_clock) disable iff (!i_nrst)
    (i_mode == `HBSRT_SMODE_ALL3) |=>
    ((level_ff ^ $past(level_ff)) &
     ($past(pt1_ff ^ pt2_ff) | $past(pt2_ff ^ pt3_ff))) == '0)
    else $error("strobe changed without all three samples agreeing");
  AST_ONE_POINT: assert property ( // RULE6
    @(posedge i_clock) disable iff (!i_nrst)
    (i_mode == `HBSRT_SMODE_P1) |=> (level_ff == $past(pt1_ff)))
    else $error("one point mode did not follow sample point one");

endmodule : hbsrt_strobe_filter

`default_nettype wire

// [hbsrt_host_bus.sv]
// Purpose: host parallel bus front end with ready timeout
// Assumes: host bus clock not faster than i_clock
// Notes: strobes cross via synchroniser, address and data via
// Notes: host-clock holding registers read while strobes stand
`timescale 1ns/1ps
`default_nettype none
`include "hbsrt_defs.svh"

// What this block does
// (RULE1) synchronise host strobes, address, data before use
// (RULE2) separate write and read synchronisation paths
// (RULE3) dma handshake input bypasses synchroniser, host clock
// (RULE4) strobes three samples, address/data at point two
// (RULE5) mode 00 all three agree, 01 majority
// (RULE6) mode 10 points one and two, 11 point one
// (RULE7) same filtering for reads and writes
// (RULE8) read strobe wins over write strobe
// (RULE9) ready high at once when chip select high
// (RULE10) drive data only while select and read low
// (RULE11) load timeout counter at read cycle start
// (RULE12) expired counter forces ready high, data invalid
// (RULE13) timeout sets sticky error flag
// (RULE14) timeout captures 21-bit failing read address
// (RULE15) enable low disables counter and timeout
// (RULE16) read cycle means select and read low
// (RULE17) timeout runtime ends when counter reaches zero
// (RULE18) strobes pass core flip-flops before filtering
// (RULE19) host bus clock at most core clock
module hbsrt_host_bus import hbsrt_pkg::*; (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_host_clock,
  input wire logic i_host_chip_select_n,
  input wire logic i_host_write_strobe_n,
  input wire logic i_host_read_strobe_n,
  input wire logic [`HBSRT_ADDR_W-1:0] i_host_bus_address,
  input wire logic [`HBSRT_DATA_W-1:0] i_host_data_in,
  input wire logic i_host_dma_ack_n,
  output logic o_host_dma_ack_seen_n,
  output logic o_host_ready_out,
  output logic [`HBSRT_DATA_W-1:0] o_host_data_out,
  output logic o_host_data_oe,
  input wire logic [`HBSRT_SMODE_W-1:0] i_strobe_sample_mode,
  input wire logic [`HBSRT_TO_W-1:0] i_ready_timeout_value,
  input wire logic i_ready_timeout_enable,
  input wire logic i_error_flag_clear,
  output logic o_ready_timeout_error_flag,
  output logic [`HBSRT_ADDR_W-1:0] o_timeout_fault_address,
  output logic o_core_read_req,
  output logic o_core_write_req,
  output hbsrt_req_s o_core_request,
  input wire logic [`HBSRT_DATA_W-1:0] i_core_read_data,
  input wire logic i_core_read_valid
);

  hbsrt_req_s host_req_ff;
  logic dma_ack_ff;
  hbsrt_strobe_t sync_level;
  hbsrt_strobe_t filt_level;
  hbsrt_strobe_t point2;
  hbsrt_req_s cap_ff;
  logic p2_seen_ff;
  logic access_p2;
  logic cs_seen_high;
  logic read_active;
  logic write_active;
  hbsrt_state_e state_ff;
  hbsrt_state_e nxt_state;
  logic [`HBSRT_TO_W-1:0] cnt_ff;
  logic timeout_now;
  logic ready_ff;
  logic nxt_ready;
  logic oe_ff;
  logic [`HBSRT_DATA_W-1:0] rdata_ff;
  logic err_ff;
  logic [`HBSRT_ADDR_W-1:0] fault_ff;
  logic rreq_ff;
  logic wreq_ff;
  hbsrt_req_s req_ff;

  // host-clock holding register for address and write data
  always_ff @(posedge i_host_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      host_req_ff <= '0;
    end else begin
      host_req_ff <= {i_host_bus_address, i_host_data_in}; // RULE1
    end
  end

  // dma handshake taken on the host clock, no synchroniser
  always_ff @(posedge i_host_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      dma_ack_ff <= 1'b1;
    end else begin
      dma_ack_ff <= i_host_dma_ack_n; // RULE3
    end
  end

  assign o_host_dma_ack_seen_n = dma_ack_ff;

  // write-direction sync point: strobes into the core domain
  hbsrt_sync3 #(
    .WIDTH(`HBSRT_NSTROBE)
  ) u_sync (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_async({i_host_read_strobe_n, i_host_write_strobe_n,
              i_host_chip_select_n}),
    .o_level(sync_level)
  );

  // sample points and mode filter
  hbsrt_strobe_filter u_filter (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_level(sync_level),
    .i_mode(i_strobe_sample_mode),
    .o_point2(point2),
    .o_level(filt_level)
  );

  // access decode, read wins over write
  assign cs_seen_high = sync_level[`HBSRT_IDX_CS];
  assign read_active = !filt_level[`HBSRT_IDX_CS] &&
                       !filt_level[`HBSRT_IDX_RD]; // RULE16
  assign write_active = !filt_level[`HBSRT_IDX_CS] &&
                        !filt_level[`HBSRT_IDX_WR] &&
                        filt_level[`HBSRT_IDX_RD]; // RULE8
  assign access_p2 = !point2[`HBSRT_IDX_CS] &&
                     (!point2[`HBSRT_IDX_RD] || !point2[`HBSRT_IDX_WR]);

  // address and data taken once, at sample point two
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cap_ff <= '0;
      p2_seen_ff <= 1'b0;
    end else begin
      p2_seen_ff <= access_p2;
      if (access_p2 && !p2_seen_ff) begin
        cap_ff <= host_req_ff; // RULE4 RULE1
      end
    end
  end

  // timeout expires at zero while enabled and no data came
  assign timeout_now = (state_ff == HBSRT_READ_WAIT) && !cs_seen_high &&
                       !i_core_read_valid && i_ready_timeout_enable &&
                       (cnt_ff == `HBSRT_TO_ZERO); // RULE15 RULE17

  // access sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      HBSRT_IDLE: begin
        if (read_active) begin
          nxt_state = HBSRT_READ_WAIT;
        end else if (write_active) begin
          nxt_state = HBSRT_WRITE_HOLD;
        end
      end
      HBSRT_READ_WAIT: begin
        if (cs_seen_high) begin
          nxt_state = HBSRT_READ_DONE; // wait for filter, no second request
        end else if (i_core_read_valid || timeout_now) begin
          nxt_state = HBSRT_READ_DONE;
        end
      end
      HBSRT_READ_DONE, HBSRT_WRITE_HOLD: begin
        if (!read_active && !write_active) begin
          nxt_state = HBSRT_IDLE;
        end
      end
      default: nxt_state = HBSRT_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= HBSRT_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // timeout down-counter, loaded as each read cycle starts
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_ff <= `HBSRT_TO_ZERO;
    end else if (state_ff == HBSRT_IDLE && read_active) begin
      cnt_ff <= i_ready_timeout_value; // RULE11
    end else if (state_ff == HBSRT_READ_WAIT && i_ready_timeout_enable &&
                 cnt_ff != `HBSRT_TO_ZERO) begin
      cnt_ff <= cnt_ff - `HBSRT_TO_ONE; // RULE15
    end
  end

  // ready: high while deselected, low only while a read waits
  always_comb begin
    nxt_ready = 1'b1;
    if (cs_seen_high) begin
      nxt_ready = 1'b1; // RULE9
    end else if (state_ff == HBSRT_IDLE && read_active) begin
      nxt_ready = 1'b0;
    end else if (state_ff == HBSRT_READ_WAIT) begin
      nxt_ready = i_core_read_valid || timeout_now; // RULE12
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ready_ff <= 1'b1;
    end else begin
      ready_ff <= nxt_ready;
    end
  end

  // read-direction sync point: core data into the output register
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_ff <= `HBSRT_DATA_RST;
    end else if (state_ff == HBSRT_READ_WAIT && i_core_read_valid) begin
      rdata_ff <= i_core_read_data; // RULE2
    end
  end

  // data bus driver enable, dropped once select or read is seen high
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= read_active && !cs_seen_high &&
               !sync_level[`HBSRT_IDX_RD]; // RULE10
    end
  end

  // sticky error flag, a new timeout beats a clear
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      err_ff <= 1'b0;
    end else if (timeout_now) begin
      err_ff <= 1'b1; // RULE13
    end else if (i_error_flag_clear) begin
      err_ff <= 1'b0;
    end
  end

  // failing read address
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      fault_ff <= `HBSRT_ADDR_RST;
    end else if (timeout_now) begin
      fault_ff <= cap_ff.addr; // RULE14
    end
  end

  // one-cycle requests toward the core
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rreq_ff <= 1'b0;
      wreq_ff <= 1'b0;
      req_ff <= '0;
    end else begin
      rreq_ff <= (state_ff == HBSRT_IDLE) && read_active;
      wreq_ff <= (state_ff == HBSRT_IDLE) && write_active; // RULE8
      if (state_ff == HBSRT_IDLE && (read_active || write_active)) begin
        req_ff <= cap_ff;
      end
    end
  end

  assign o_host_ready_out = ready_ff;
  assign o_host_data_out = rdata_ff;
  assign o_host_data_oe = oe_ff;
  assign o_ready_timeout_error_flag = err_ff;
  assign o_timeout_fault_address = fault_ff;
  assign o_core_read_req = rreq_ff;
  assign o_core_write_req = wreq_ff;
  assign o_core_request = req_ff;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  // bus-side checks, core clock unless named otherwise
  AST_READY_ON_DESELECT: assert property ( // RULE9
    cs_seen_high |=> o_host_ready_out)
    else $error("ready low although chip select was high");
  AST_OE_ONLY_READ: assert property ( // RULE10
    o_host_data_oe |->
    $past(!filt_level[`HBSRT_IDX_CS] && !filt_level[`HBSRT_IDX_RD]))
    else $error("data bus driven outside a read cycle");
  AST_COUNTER_LOAD: assert property ( // RULE11
    (state_ff == HBSRT_IDLE) && read_active |=>
    (cnt_ff == $past(i_ready_timeout_value)) &&
    (state_ff == HBSRT_READ_WAIT) &&
    (o_host_ready_out == $past(cs_seen_high)))
    else $error("timeout counter not loaded at read start");
  AST_TIMEOUT_READY: assert property ( // RULE12
    timeout_now |=> o_host_ready_out && (state_ff == HBSRT_READ_DONE))
    else $error("timeout did not release ready");
  AST_TIMEOUT_FLAG: assert property ( // RULE13
    timeout_now |=> o_ready_timeout_error_flag)
    else $error("timeout did not set the error flag");
  AST_FAULT_ADDR: assert property ( // RULE14
    timeout_now |=> o_timeout_fault_address == $past(cap_ff.addr))
    else $error("fault address not captured");
  AST_DISABLED_NO_TIMEOUT: assert property ( // RULE15
    !i_ready_timeout_enable && (state_ff == HBSRT_READ_WAIT) |=>
    !o_ready_timeout_error_flag || $past(o_ready_timeout_error_flag))
    else $error("timeout raised while disabled");
  AST_TIMEOUT_AT_ZERO: assert property ( // RULE17
    (state_ff == HBSRT_IDLE) && read_active &&
    (i_ready_timeout_value == `HBSRT_TO_ONE) && i_ready_timeout_enable
    ##1 (!cs_seen_high && !i_core_read_valid && i_ready_timeout_enable) [*2]
    |-> timeout_now)
    else $error("timeout did not end when counter reached zero");
  AST_READ_WINS: assert property ( // RULE8
    (state_ff == HBSRT_IDLE) && read_active |=>
    o_core_read_req && !o_core_write_req)
    else $error("write request issued for a read access");
  AST_READ_CYCLE: assert property ( // RULE16
    (state_ff == HBSRT_IDLE) && !filt_level[`HBSRT_IDX_CS] &&
    !filt_level[`HBSRT_IDX_RD] |=> (state_ff == HBSRT_READ_WAIT))
    else $error("read cycle not recognised");
  AST_DATA_ON_VALID: assert property ( // RULE2
    (state_ff == HBSRT_READ_WAIT) && i_core_read_valid |=>
    o_host_data_out == $past(i_core_read_data))
    else $error("read data not taken from the core");
  AST_DMA_DIRECT: assert property ( // RULE3
    @(posedge i_host_clock)
    o_host_dma_ack_seen_n == $past(i_host_dma_ack_n))
    else $error("dma acknowledge not taken on the host clock");

  COV_READ_DATA: cover property (
    (state_ff == HBSRT_READ_WAIT) && i_core_read_valid);
  COV_TIMEOUT: cover property (timeout_now);
  COV_WRITE: cover property (o_core_write_req);
  COV_SET_BEATS_CLEAR: cover property (timeout_now && i_error_flag_clear);

endmodule : hbsrt_host_bus

`default_nettype wire

// [hbsrt_host_model.sv]
// Purpose: host controller model driving the parallel bus
// Assumes: bus signals change just after a host clock rising edge
// Notes: released address and data lines show the inverted value
`timescale 1ns/1ps
`include "hbsrt_defs.svh"
`default_nettype none

module hbsrt_host_model import hbsrt_pkg::*; (
  input wire logic i_host_clock,
  input wire logic i_ready,
  input wire logic [`HBSRT_DATA_W-1:0] i_bus,
  output logic o_cs_n,
  output logic o_wr_n,
  output logic o_rd_n,
  output logic [`HBSRT_ADDR_W-1:0] o_addr,
  output logic [`HBSRT_DATA_W-1:0] o_wdata
);
  // idle bus: strobes high
  initial begin
    o_cs_n = 1'b1;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    o_addr = `HBSRT_ADDR_RST;
    o_wdata = `HBSRT_DATA_RST;
  end

  // one access: strobes stand until ready on reads, then idle gap
  task automatic access(input logic is_rd, input logic is_wr,
      input logic [`HBSRT_ADDR_W-1:0] a,
      input logic [`HBSRT_DATA_W-1:0] d,
      output logic [`HBSRT_DATA_W-1:0] q);
    int n;
    n = 0;
    @(posedge i_host_clock);
    #1;
    o_cs_n = 1'b0;
    o_rd_n = ~is_rd;
    o_wr_n = ~is_wr;
    o_addr = a;
    o_wdata = d;
    repeat (8) @(posedge i_host_clock);
    while (is_rd && i_ready !== 1'b1 && n < 100) begin
      @(posedge i_host_clock);
      n++;
    end
    q = i_bus;
    #1;
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_addr = ~a;
    o_wdata = ~d;
    repeat (10) @(posedge i_host_clock);
  endtask : access

  // disturbance: short dip of select and read strobe
  task automatic pulse(input int ns);
    @(posedge i_host_clock);
    #1;
    o_cs_n = 1'b0;
    o_rd_n = 1'b0;
    #(ns);
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
  endtask : pulse
endmodule : hbsrt_host_model

`default_nettype wire

// [hbsrt_host_bus_tb.sv]
// Purpose: self-checking bench of the host bus front end
// Assumes: core answers reads with a one-cycle valid pulse
// Notes: ready delay counted in core cycles from the read pulse
`timescale 1ns/1ps
`include "hbsrt_defs.svh"
`default_nettype none

module hbsrt_host_bus_tb import hbsrt_pkg::*;;
  typedef struct packed {
    logic [1:0] mode;
    logic rd;
    logic wr;
    logic [7:0] lat;
    logic [7:0] v;
    logic en;
    logic [20:0] addr;
    logic [31:0] data;
  } hbsrt_row_s;
  logic i_clock = 1'b0, i_nrst = 1'b0, i_host_clock = 1'b0;
  logic cs_n, wr_n, rd_n, ready, oe, flag, rreq, wreq_p, dma_seen_n;
  logic [20:0] addr, fault, rq_addr, exp_fault;
  logic [31:0] wdata, rdata, host_bus, q, exp_rdata;
  logic [1:0] i_mode = 2'h0;
  logic [7:0] i_tov = 8'h00, lat = 8'hff;
  logic i_toen = 1'b0, i_clr = 1'b0, i_dma = 1'b1, i_valid = 1'b0;
  logic [31:0] i_cdata = 32'h0000_0000;
  logic run = 1'b0, is_to;
  hbsrt_req_s req, wreq;
  hbsrt_row_s rows [9];
  hbsrt_row_s r;
  int n_mismatch = 0, samples_checked = 0, cycles = 0;
  int rd_cnt = 0, wr_cnt = 0, t = 0, rise = 0, n_rd0, n_wr0;

  // clocks, the host one slower and out of phase
  always #25 i_clock = ~i_clock;
  initial begin
    #7;
    forever #40 i_host_clock = ~i_host_clock;
  end
  // released data lines show the inverted value
  assign host_bus = oe ? rdata : ~rdata;

  hbsrt_host_model host_u (.i_host_clock(i_host_clock), .i_ready(ready),
    .i_bus(host_bus), .o_cs_n(cs_n), .o_wr_n(wr_n), .o_rd_n(rd_n),
    .o_addr(addr), .o_wdata(wdata));
  hbsrt_host_bus dut_u (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_host_clock(i_host_clock), .i_host_chip_select_n(cs_n),
    .i_host_write_strobe_n(wr_n), .i_host_read_strobe_n(rd_n),
    .i_host_bus_address(addr), .i_host_data_in(wdata),
    .i_host_dma_ack_n(i_dma), .o_host_dma_ack_seen_n(dma_seen_n),
    .o_host_ready_out(ready), .o_host_data_out(rdata),
    .o_host_data_oe(oe), .i_strobe_sample_mode(i_mode),
    .i_ready_timeout_value(i_tov), .i_ready_timeout_enable(i_toen),
    .i_error_flag_clear(i_clr), .o_ready_timeout_error_flag(flag),
    .o_timeout_fault_address(fault), .o_core_read_req(rreq),
    .o_core_write_req(wreq_p), .o_core_request(req),
    .i_core_read_data(i_cdata), .i_core_read_valid(i_valid));

  task automatic check(input string what, input logic [63:0] seen,
      input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // core side: count requests, answer reads after lat cycles
  always @(negedge i_clock) begin
    if (rreq === 1'b1) begin
      rd_cnt++;
      rq_addr = req.addr;
      run = 1'b1;
      t = 0;
    end else if (run) begin
      t++;
    end
    if (wreq_p === 1'b1) begin
      wr_cnt++;
      wreq = req;
    end
    if (run && t > 0 && ready === 1'b1) begin
      rise = t;
      run = 1'b0;
    end
    i_valid = run && (t == lat);
  end

  // hang guard
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    rows[0] = '{2'h0,1'b1,1'b0,8'h03,8'h0a,1'b1,21'h0_1234,32'ha5a5_0001};
    rows[1] = '{2'h1,1'b0,1'b1,8'h00,8'h00,1'b1,21'h1_0004,32'h5a5a_0002};
    rows[2] = '{2'h2,1'b1,1'b0,8'h02,8'h08,1'b1,21'h0_0abc,32'hc3c3_0003};
    rows[3] = '{2'h3,1'b0,1'b1,8'h00,8'h00,1'b1,21'h1f_fffc,32'hffff_0004};
    rows[4] = '{2'h0,1'b1,1'b1,8'h01,8'h05,1'b1,21'h0_0020,32'h1234_0005};
    rows[5] = '{2'h1,1'b1,1'b0,8'h14,8'h01,1'b1,21'h1a_5a50,32'hdead_0006};
    rows[6] = '{2'h2,1'b1,1'b0,8'h06,8'h02,1'b0,21'h0_4444,32'h0f0f_0007};
    rows[7] = '{2'h3,1'b1,1'b0,8'h09,8'hff,1'b1,21'h0_7770,32'h7777_0008};
    rows[8] = '{2'h3,1'b1,1'b0,8'h1e,8'h00,1'b1,21'h15_5550,32'hbeef_0009};
    exp_rdata = 32'h0000_0000;
    exp_fault = 21'h0_0000;
    repeat (5) @(negedge i_clock);
    i_nrst = 1'b1;
    // table of reads, writes and timeouts, each mode used two or three times
    for (int i = 0; i < 9; i++) begin
      r = rows[i];
      n_rd0 = rd_cnt;
      n_wr0 = wr_cnt;
      @(negedge i_clock);
      i_mode = r.mode;
      i_tov = r.v;
      i_toen = r.en;
      lat = r.lat;
      i_cdata = r.data;
      i_clr = 1'b1;
      @(negedge i_clock);
      i_clr = 1'b0;
      host_u.access(r.rd, r.wr, r.addr, r.data, q);
      is_to = r.rd && r.en && (r.v < r.lat);
      check("reads", 64'(rd_cnt - n_rd0), 64'(r.rd));
      check("writes", 64'(wr_cnt - n_wr0), 64'(r.wr & ~r.rd));
      if (r.rd) begin
        check("read addr", 64'(rq_addr), 64'(r.addr));
        check("ready delay", 64'(rise),
          64'((is_to ? r.v : r.lat) + 1));
        check("read data", 64'(q), 64'(is_to ? exp_rdata : r.data));
        if (!is_to) begin
          exp_rdata = r.data;
        end else begin
          exp_fault = r.addr;
        end
      end else begin
        check("write req", 64'(wreq), 64'({r.addr, r.data}));
      end
      check("error flag", 64'(flag), 64'(is_to));
      check("fault addr", 64'(fault), 64'(exp_fault));
      check("oe idle", 64'(oe), 64'd0);
      check("ready idle", 64'(ready), 64'd1);
    end
    // two-cycle dip: refused by all-three, taken by point one
    @(negedge i_clock);
    i_mode = 2'h0;
    i_toen = 1'b0;
    lat = 8'hff;
    n_rd0 = rd_cnt;
    host_u.pulse(100);
    repeat (30) @(negedge i_clock);
    check("dip all3", 64'(rd_cnt - n_rd0), 64'd0);
    i_mode = 2'h3;
    host_u.pulse(100);
    repeat (30) @(negedge i_clock);
    check("dip pt1", 64'(rd_cnt - n_rd0), 64'd1);
    check("ready deselect", 64'(ready), 64'd1);
    check("oe deselect", 64'(oe), 64'd0);
    // dma ack is taken on the host clock alone
    i_dma = 1'b0;
    repeat (2) @(posedge i_host_clock);
    @(negedge i_clock);
    check("dma ack", 64'(dma_seen_n), 64'd0);
    i_dma = 1'b1;
    // second reset in mid-run after a timeout
    repeat (4) @(negedge i_clock);
    i_nrst = 1'b0;
    repeat (4) @(negedge i_clock);
    check("rst ready", 64'(ready), 64'd1);
    check("rst oe", 64'(oe), 64'd0);
    check("rst flag", 64'(flag), 64'd0);
    check("rst fault", 64'(fault), 64'd0);
    check("rst dma", 64'(dma_seen_n), 64'd1);
    i_nrst = 1'b1;
    @(negedge i_clock);
    check("rst reqs", 64'({rreq, wreq_p}), 64'd0);
    give_verdict();
  end
endmodule : hbsrt_host_bus_tb

`default_nettype wire
